// ==== vfe_top.sv ====
// Gain, clamp and stability control of a video front end.
// Assumes AXI4-Lite on aclk, and front-end measurement inputs that are
// already synchronous to aclk, each event a one-cycle pulse.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
module vfe_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Front-end measurements
    input wire logic field_end,
    input wire logic [1:0] measured_format,
    input wire logic measured_lines_625,
    input wire logic line_start,
    input wire logic vblank,
    input wire logic sync_sample_valid,
    input wire logic [7:0] sync_height,
    input wire logic adc_overflow,
    input wire logic [11:0] digital_gain_auto_value,
    // Front-end controls
    output logic [5:0] analog_gain,
    output logic [11:0] digital_gain,
    output logic [2:0] clamp_level,
    output logic clamp_active,
    output logic porch_update_enable,
    output logic gain_locked,
    output logic [1:0] detected_format,
    output logic detected_lines_625,
    output logic [7:0] sync_height_target,
    output logic [3:0] sync_loop_shift,
    output logic [3:0] digital_gain_loop_shift,
    output logic [3:0] porch_clamp_loop_shift,
    output logic [3:0] porch_level_loop_shift,
    output logic [15:0] subcarrier_correlator_limit,
    output logic [7:0] porch_line_share,
    output logic [24:0] pll_adjust_limit
);
    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    logic [7:0] fmt_cfg_ff; // Stability field codes
    logic [5:0] again_ff; // Analog gain
    logic [11:0] dgain_ff; // Digital gain
    logic [1:0] clamp_skip_ff; // Lines without clamping
    logic [7:0] fe_ctrl_ff; // Front-end mode bits
    logic [7:0] sync_tgt_ff; // Sync height target
    logic [7:0] track_ff; // Unlock window
    logic [7:0] acq_ff; // Lock window
    logic [7:0] loop_gain_ff; // Loop gain exponents
    logic [1:0] bp_gain_ff; // Porch level exponent
    logic [7:0] sc_thr_ff; // Correlator setting
    logic [7:0] bp_share_ff; // Porch share
    logic [15:0] pll_ff; // PLL adjust limit
    // ---------------------------------------------------------------
    // AXI write channel
    // ---------------------------------------------------------------
    logic aw_held_ff; // Address taken, waiting for data
    logic w_held_ff; // Data taken, waiting for address
    logic [11:0] aw_idx_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    // Either channel is taken alone; no new write until response leaves
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_ff || aw_fire;
    wire w_have = w_held_ff || w_fire;
    wire wr_go = aw_have && w_have;
    wire [11:0] wr_idx = aw_held_ff ? aw_idx_ff : s_axi_awaddr[13:2];
    wire [7:0] wr_byte = w_held_ff ? wdata_ff[7:0] : s_axi_wdata[7:0];
    wire wr_lane = w_held_ff ? wstrb_ff[0] : s_axi_wstrb[0];
    wire wr_en = wr_go && wr_lane;
    wire wr_known = (wr_idx >= vfe_pkg::IDX_FMT_CFG) && (wr_idx <= vfe_pkg::IDX_PLL_HI);

    // Channel holding and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_idx_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= vfe_pkg::RESP_OKAY;
        end else begin
            aw_held_ff <= aw_have && !wr_go;
            w_held_ff <= w_have && !wr_go;
            if (aw_fire) begin
                aw_idx_ff <= s_axi_awaddr[13:2];
            end
            if (w_fire) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_known ? vfe_pkg::RESP_OKAY : vfe_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Named write strobes
    wire we_fmt = wr_en && (wr_idx == vfe_pkg::IDX_FMT_CFG);
    wire we_again = wr_en && (wr_idx == vfe_pkg::IDX_AGAIN);
    wire we_dlo = wr_en && (wr_idx == vfe_pkg::IDX_DGAIN_LO);
    wire we_dhi = wr_en && (wr_idx == vfe_pkg::IDX_DGAIN_HI);
    wire we_fe = wr_en && (wr_idx == vfe_pkg::IDX_FE_CTRL);
    wire we_sync = wr_en && (wr_idx == vfe_pkg::IDX_SYNC_TGT);
    wire we_track = wr_en && (wr_idx == vfe_pkg::IDX_TRACK);
    wire we_acq = wr_en && (wr_idx == vfe_pkg::IDX_ACQ);
    wire we_lg = wr_en && (wr_idx == vfe_pkg::IDX_LOOP_GAIN);
    wire we_bp = wr_en && (wr_idx == vfe_pkg::IDX_BP_GAIN);
    wire we_sc = wr_en && (wr_idx == vfe_pkg::IDX_SC_THR);
    wire we_share = wr_en && (wr_idx == vfe_pkg::IDX_BP_SHARE);
    wire we_plo = wr_en && (wr_idx == vfe_pkg::IDX_PLL_LO);
    wire we_phi = wr_en && (wr_idx == vfe_pkg::IDX_PLL_HI);

    // Mode bits
    wire again_auto = fe_ctrl_ff[vfe_pkg::FE_AGAIN_AUTO];
    wire dgain_auto = fe_ctrl_ff[vfe_pkg::FE_DGAIN_AUTO];
    wire clamp_auto = fe_ctrl_ff[vfe_pkg::FE_CLAMP_AUTO];
    wire crush_en = fe_ctrl_ff[vfe_pkg::FE_CRUSH];
    wire gate_en = fe_ctrl_ff[vfe_pkg::FE_GATE];

    // ---------------------------------------------------------------
    // Automatic analog gain loop
    // ---------------------------------------------------------------
    // Error magnitude of the measured sync height against the target
    wire [7:0] err_mag = (sync_height >= sync_tgt_ff) ? (sync_height - sync_tgt_ff)
                                                      : (sync_tgt_ff - sync_height);
    wire too_high = sync_height > sync_tgt_ff;
    wire too_low = sync_height < sync_tgt_ff;
    // One gain step per sample keeps the loop slow and monotonic
    wire [5:0] again_step = (too_high && again_ff != 6'h00) ? again_ff - 6'h01 :
                            (too_low && again_ff != 6'h3f) ? again_ff + 6'h01 : again_ff;
    logic locked_ff;

    // Plain settings and the gain loop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmt_cfg_ff <= vfe_pkg::RST_FMT_CFG;
            again_ff <= vfe_pkg::RST_AGAIN;
            dgain_ff <= vfe_pkg::RST_DGAIN;
            clamp_skip_ff <= vfe_pkg::RST_CLAMP_SKIP;
            fe_ctrl_ff <= vfe_pkg::RST_FE_CTRL;
            sync_tgt_ff <= vfe_pkg::RST_SYNC_TGT;
            track_ff <= vfe_pkg::RST_TRACK;
            acq_ff <= vfe_pkg::RST_ACQ;
            loop_gain_ff <= vfe_pkg::RST_LOOP_GAIN;
            bp_gain_ff <= vfe_pkg::RST_BP_GAIN;
            sc_thr_ff <= vfe_pkg::RST_SC_THR;
            bp_share_ff <= vfe_pkg::RST_BP_SHARE;
            pll_ff <= vfe_pkg::RST_PLL;
            locked_ff <= 1'b0;
        end else begin
            if (we_fmt) fmt_cfg_ff <= {wr_byte[7:4], 4'h0};
            if (we_fe) fe_ctrl_ff <= wr_byte;
            if (we_track) track_ff <= wr_byte;
            if (we_acq) acq_ff <= wr_byte;
            if (we_lg) loop_gain_ff <= {wr_byte[7:6], 2'h0, wr_byte[3:0]};
            if (we_bp) bp_gain_ff <= wr_byte[1:0];
            if (we_sc) sc_thr_ff <= wr_byte;
            if (we_share) bp_share_ff <= wr_byte;
            if (we_plo) pll_ff[7:0] <= wr_byte;
            if (we_phi) pll_ff[15:8] <= wr_byte;
            if (we_dhi) clamp_skip_ff <= wr_byte[5:4];
            // Overflow protection lowers the target; software write wins
            if (we_sync) begin
                sync_tgt_ff <= wr_byte;
            end else if (crush_en && adc_overflow && sync_tgt_ff != 8'h00) begin
                sync_tgt_ff <= sync_tgt_ff - 8'h01;
            end
            // Analog gain: loop in auto, software in manual
            if (again_auto) begin
                if (sync_sample_valid) again_ff <= again_step;
            end else if (we_again) begin
                again_ff <= wr_byte[5:0];
            end
            // Digital gain: loop value in auto, frozen or written in manual
            if (dgain_auto) begin
                dgain_ff <= digital_gain_auto_value;
            end else begin
                if (we_dlo) dgain_ff[7:0] <= wr_byte;
                if (we_dhi) dgain_ff[11:8] <= wr_byte[3:0];
            end
            // Lock hysteresis between acquire and track windows
            if (sync_sample_valid) begin
                if (!locked_ff && err_mag <= acq_ff) locked_ff <= 1'b1;
                else if (locked_ff && err_mag >= track_ff) locked_ff <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Format and line-count stability
    // ---------------------------------------------------------------
    logic [1:0] fmt_cand_ff;
    logic [4:0] fmt_cnt_ff;
    logic [1:0] fmt_det_ff;
    logic lines_cand_ff;
    logic [4:0] lines_cnt_ff;
    logic lines_det_ff;
    // Codes 0..3 give 2, 4, 8 and 16 fields
    wire [4:0] fmt_need = 5'h02 << fmt_cfg_ff[7:6];
    wire [4:0] lines_need = 5'h02 << fmt_cfg_ff[5:4];

    // Candidate tracking per field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmt_cand_ff <= 2'h0;
            fmt_cnt_ff <= 5'h00;
            fmt_det_ff <= 2'h0;
            lines_cand_ff <= 1'b0;
            lines_cnt_ff <= 5'h00;
            lines_det_ff <= 1'b0;
        end else if (field_end) begin
            if (measured_format != fmt_cand_ff) begin
                fmt_cand_ff <= measured_format;
                fmt_cnt_ff <= 5'h01;
            end else if (fmt_cnt_ff + 5'h01 >= fmt_need) begin
                fmt_det_ff <= fmt_cand_ff;
                fmt_cnt_ff <= fmt_need;
            end else begin
                fmt_cnt_ff <= fmt_cnt_ff + 5'h01;
            end
            if (measured_lines_625 != lines_cand_ff) begin
                lines_cand_ff <= measured_lines_625;
                lines_cnt_ff <= 5'h01;
            end else if (lines_cnt_ff + 5'h01 >= lines_need) begin
                lines_det_ff <= lines_cand_ff;
                lines_cnt_ff <= lines_need;
            end else begin
                lines_cnt_ff <= lines_cnt_ff + 5'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Clamp skipping after each line start
    // ---------------------------------------------------------------
    logic [1:0] skip_ff;
    logic [2:0] clamp_ff;
    logic gate_ff;

    // Output registers for clamp and gating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            skip_ff <= 2'h0;
            clamp_ff <= 3'h0;
            gate_ff <= 1'b1;
        end else begin
            if (line_start && skip_ff == 2'h0) skip_ff <= clamp_skip_ff;
            else if (line_start) skip_ff <= skip_ff - 2'h1;
            clamp_ff <= clamp_auto ? again_ff[5:3] : fe_ctrl_ff[2:0];
            gate_ff <= !(gate_en && vblank);
        end
    end

    // ---------------------------------------------------------------
    // AXI read channel
    // ---------------------------------------------------------------
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    wire [11:0] rd_idx = s_axi_araddr[13:2];
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    wire rd_known = (rd_idx >= vfe_pkg::IDX_FMT_CFG) && (rd_idx <= vfe_pkg::IDX_PLL_HI);
    wire [7:0] status_byte = {3'h0, locked_ff, lines_det_ff, fmt_det_ff, skip_ff == 2'h0};
    logic [7:0] rd_byte;

    // Read selection
    always_comb begin
        case (rd_idx)
            vfe_pkg::IDX_FMT_CFG: rd_byte = fmt_cfg_ff;
            vfe_pkg::IDX_AGAIN: rd_byte = {2'h0, again_ff};
            vfe_pkg::IDX_DGAIN_LO: rd_byte = dgain_ff[7:0];
            vfe_pkg::IDX_DGAIN_HI: rd_byte = {2'h0, clamp_skip_ff, dgain_ff[11:8]};
            vfe_pkg::IDX_FE_CTRL: rd_byte = fe_ctrl_ff;
            vfe_pkg::IDX_SYNC_TGT: rd_byte = sync_tgt_ff;
            vfe_pkg::IDX_TRACK: rd_byte = track_ff;
            vfe_pkg::IDX_ACQ: rd_byte = acq_ff;
            vfe_pkg::IDX_LOOP_GAIN: rd_byte = loop_gain_ff;
            vfe_pkg::IDX_STATUS: rd_byte = status_byte;
            vfe_pkg::IDX_BP_GAIN: rd_byte = {6'h00, bp_gain_ff};
            vfe_pkg::IDX_SC_THR: rd_byte = sc_thr_ff;
            vfe_pkg::IDX_BP_SHARE: rd_byte = bp_share_ff;
            vfe_pkg::IDX_PLL_LO: rd_byte = pll_ff[7:0];
            vfe_pkg::IDX_PLL_HI: rd_byte = pll_ff[15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    // Read response register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= vfe_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_byte};
            rresp_ff <= rd_known ? vfe_pkg::RESP_OKAY : vfe_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign analog_gain = again_ff;
    assign digital_gain = dgain_ff;
    assign clamp_level = clamp_ff;
    assign clamp_active = (skip_ff == 2'h0);
    assign porch_update_enable = gate_ff;
    assign gain_locked = locked_ff;
    assign detected_format = fmt_det_ff;
    assign detected_lines_625 = lines_det_ff;
    assign sync_height_target = sync_tgt_ff;
    // Shift n stands for gain 2^n/4: downstream divides by four
    assign sync_loop_shift = {2'h0, loop_gain_ff[7:6]};
    assign digital_gain_loop_shift = {2'h0, loop_gain_ff[3:2]};
    assign porch_clamp_loop_shift = {2'h0, loop_gain_ff[1:0]};
    assign porch_level_loop_shift = {2'h0, bp_gain_ff};
    assign subcarrier_correlator_limit = {sc_thr_ff, 8'h00};
    assign porch_line_share = bp_share_ff;
    assign pll_adjust_limit = {pll_ff, 9'h000};
endmodule

// ==== vfe_pkg.sv ====
// Constants, register map and reset values of the video front-end
// gain and clamp control block.
// Assumes an AXI4-Lite master with 32-bit data, one register per word.
package vfe_pkg;
    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [11:0] IDX_FMT_CFG = 12'h487;
    localparam logic [11:0] IDX_AGAIN = 12'h488;
    localparam logic [11:0] IDX_DGAIN_LO = 12'h489;
    localparam logic [11:0] IDX_DGAIN_HI = 12'h48a;
    localparam logic [11:0] IDX_FE_CTRL = 12'h48b;
    localparam logic [11:0] IDX_SYNC_TGT = 12'h48c;
    localparam logic [11:0] IDX_TRACK = 12'h48d;
    localparam logic [11:0] IDX_ACQ = 12'h48e;
    localparam logic [11:0] IDX_LOOP_GAIN = 12'h48f;
    localparam logic [11:0] IDX_STATUS = 12'h490;
    localparam logic [11:0] IDX_BP_GAIN = 12'h491;
    localparam logic [11:0] IDX_SC_THR = 12'h492;
    localparam logic [11:0] IDX_BP_SHARE = 12'h493;
    localparam logic [11:0] IDX_PLL_LO = 12'h494;
    localparam logic [11:0] IDX_PLL_HI = 12'h495;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_FMT_CFG = 8'h40;
    localparam logic [5:0] RST_AGAIN = 6'h20;
    localparam logic [11:0] RST_DGAIN = 12'h100;
    localparam logic [1:0] RST_CLAMP_SKIP = 2'h2;
    localparam logic [7:0] RST_FE_CTRL = 8'hf8;
    localparam logic [7:0] RST_SYNC_TGT = 8'hdc;
    localparam logic [7:0] RST_TRACK = 8'h40;
    localparam logic [7:0] RST_ACQ = 8'h10;
    localparam logic [7:0] RST_LOOP_GAIN = 8'h8a;
    localparam logic [1:0] RST_BP_GAIN = 2'h2;
    localparam logic [7:0] RST_SC_THR = 8'h3f;
    localparam logic [7:0] RST_BP_SHARE = 8'hcd;
    localparam logic [15:0] RST_PLL = 16'h0300;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int FE_CLAMP_AUTO = 7;
    localparam int FE_DGAIN_AUTO = 6;
    localparam int FE_CRUSH = 5;
    localparam int FE_AGAIN_AUTO = 4;
    localparam int FE_GATE = 3;
    // Scaling shifts
    localparam int SC_THR_SHIFT = 8;
    localparam int PLL_SHIFT = 9;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== vfe_props.sv ====
// Port-level checks for the gain and clamp control block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module vfe_props (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Bus handshakes
    input logic s_axi_wvalid,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    // Front-end side
    input logic field_end,
    input logic vblank,
    input logic sync_sample_valid,
    input logic adc_overflow,
    input logic porch_update_enable,
    input logic gain_locked,
    input logic [1:0] detected_format,
    input logic detected_lines_625,
    input logic [7:0] sync_height_target,
    input logic [15:0] subcarrier_correlator_limit,
    input logic [24:0] pll_adjust_limit
);
    // ----------------------------------------
    // Properties, one clock domain
    // ----------------------------------------
    default clocking dflt_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    format_on_field_a: assert property ($past(aresetn) && $changed(detected_format)
        |-> $past(field_end)) else $error("format moved off field end");
    lines_on_field_a: assert property ($past(aresetn) && $changed(detected_lines_625)
        |-> $past(field_end)) else $error("lines moved off field end");
    sync_step_a: assert property ($past(aresetn) && !$past(s_axi_wvalid)
        && sync_height_target < $past(sync_height_target) |-> $past(adc_overflow)
        && sync_height_target == 8'($past(sync_height_target) - 8'h01))
        else $error("target fell without overflow");
    porch_gate_a: assert property (!vblank |=> porch_update_enable)
        else $error("porch blocked outside blanking");
    lock_on_sample_a: assert property ($past(aresetn) && $changed(gain_locked)
        |-> $past(sync_sample_valid)) else $error("lock moved without sample");
    sc_scale_a: assert property (subcarrier_correlator_limit[7:0] == 8'h00)
        else $error("correlator limit not a multiple of 256");
    pll_scale_a: assert property (pll_adjust_limit[8:0] == 9'h000)
        else $error("adjust limit not a multiple of 512");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stuck");
endmodule
bind vfe_top vfe_props vfe_props_i (.*);

// ==== vfe_fe_model.sv ====
// Behavioural front end: amplifier, clamp and ADC.
// Assumes the bench calls one task at a time, from one process.
`timescale 1ns/10ps
module vfe_fe_model (
    // Clock
    input logic aclk,
    // Measurements towards the block
    output logic field_end,
    output logic [1:0] measured_format,
    output logic measured_lines_625,
    output logic line_start,
    output logic vblank,
    output logic sync_sample_valid,
    output logic [7:0] sync_height,
    output logic adc_overflow,
    output logic [11:0] digital_gain_auto_value
);
    logic [2:0] line_cnt_ff = 3'h0; // Short lines keep the skip counter busy
    always @(posedge aclk) begin
        line_cnt_ff <= line_cnt_ff + 3'h1;
    end
    assign line_start = (line_cnt_ff == 3'h0);
    initial begin
        {field_end, measured_format, measured_lines_625, vblank} = 5'h0;
        {sync_sample_valid, sync_height, adc_overflow} = 10'h0;
        digital_gain_auto_value = 12'h5a3; // Loop output, fixed
    end
    // One field end; lines flip after it
    task automatic field(input logic [1:0] f, input logic l);
        @(posedge aclk) {field_end, measured_format, measured_lines_625} <= {1'b1, f, l};
        @(posedge aclk) {field_end, measured_format, measured_lines_625} <= {1'b0, ~f, ~l};
        @(negedge aclk);
    endtask
    // One sync height measurement
    task automatic sample(input logic [7:0] h);
        @(posedge aclk) {sync_sample_valid, sync_height} <= {1'b1, h};
        @(posedge aclk) {sync_sample_valid, sync_height} <= {1'b0, ~h};
        @(negedge aclk);
    endtask
    // Overflow held for n clocks
    task automatic overflow(input int n);
        @(posedge aclk) adc_overflow <= 1'b1;
        repeat (n) @(posedge aclk);
        adc_overflow <= 1'b0;
        @(negedge aclk);
    endtask
    // Blanking level, seen by the block at the next edge
    task automatic blank(input logic v);
        @(posedge aclk) vblank <= v;
        @(posedge aclk);
        @(negedge aclk);
    endtask
endmodule

// ==== vfe_top_tb_top.sv ====
// Self-checking bench for the gain and clamp control block.
// Assumes the front-end model drives every measurement input.
`timescale 1ns/10ps
module vfe_top_tb_top;
    typedef struct {logic [11:0] idx; logic [23:0] v; logic [1:0] resp;} vfe_row_type;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, sync_loop_shift, digital_gain_loop_shift;
    logic [3:0] porch_clamp_loop_shift, porch_level_loop_shift;
    logic [1:0] s_axi_bresp, s_axi_rresp, measured_format, detected_format;
    logic field_end, measured_lines_625, line_start, vblank, sync_sample_valid, adc_overflow;
    logic [7:0] sync_height, sync_height_target, porch_line_share;
    logic [11:0] digital_gain_auto_value, digital_gain;
    logic [5:0] analog_gain;
    logic [2:0] clamp_level;
    logic clamp_active, porch_update_enable, gain_locked, detected_lines_625;
    logic [15:0] subcarrier_correlator_limit;
    logic [24:0] pll_adjust_limit;
    int errors = 0, comparisons = 0, cycles = 0;
    // Index; reset, write and read-back bytes; response (auto gain shows loop value)
    vfe_row_type rows [15] = '{'{12'h487, 24'h40fff0, 2'h0}, '{12'h48b, 24'hf8f8f8, 2'h0},
        '{12'h488, 24'h201520, 2'h0}, '{12'h489, 24'ha355a3, 2'h0}, '{12'h48a, 24'h253f35, 2'h0},
        '{12'h48c, 24'hdcc8c8, 2'h0}, '{12'h48d, 24'h402020, 2'h0}, '{12'h48e, 24'h100808, 2'h0},
        '{12'h48f, 24'h8a4b4b, 2'h0}, '{12'h491, 24'h020101, 2'h0}, '{12'h492, 24'h3f1212, 2'h0},
        '{12'h493, 24'hcd5a5a, 2'h0}, '{12'h494, 24'h003434, 2'h0}, '{12'h495, 24'h031212, 2'h0},
        '{12'h486, 24'h00ff00, vfe_pkg::RESP_SLVERR}};
    // Heights near target 0xc5, lock left by each
    logic [7:0] heights [5] = '{8'h85, 8'hce, 8'hcd, 8'he4, 8'ha5};
    logic locks [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    vfe_top vfe_top_i (.*);
    vfe_fe_model vfe_fe_model_i (.*);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data together, each released when taken
    task automatic wr(input logic [11:0] idx, logic [7:0] d, logic [1:0] resp = 2'h0);
        logic ta, tw;
        @(posedge aclk) s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !ta;
            s_axi_wvalid <= s_axi_wvalid && !tw;
        end while (s_axi_awvalid && !ta || s_axi_wvalid && !tw);
        do @(negedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, resp);
        @(posedge aclk) s_axi_bready <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic rd(input logic [11:0] idx, logic [7:0] d, logic [1:0] resp = 2'h0);
        @(posedge aclk) s_axi_araddr <= {idx, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk) s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, {24'h0, d});
        chk(s_axi_rresp, resp);
        @(posedge aclk) s_axi_rready <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic stop_test();
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({analog_gain, digital_gain, sync_height_target}, {6'h20, 20'h100dc});
        chk({subcarrier_correlator_limit, porch_line_share}, 24'h3f00cd);
        chk(pll_adjust_limit, 25'h60000);
        chk({sync_loop_shift, digital_gain_loop_shift, porch_clamp_loop_shift}, 12'h222);
        chk(porch_level_loop_shift, 4'h2);
        // Reset value, write, read back
        foreach (rows[i]) begin
            rd(rows[i].idx, rows[i].v[23:16], rows[i].resp);
            wr(rows[i].idx, rows[i].v[15:8], rows[i].resp);
            rd(rows[i].idx, rows[i].v[7:0], rows[i].resp);
        end
        chk({sync_loop_shift, digital_gain_loop_shift, porch_clamp_loop_shift}, 12'h123);
        chk({porch_level_loop_shift, subcarrier_correlator_limit}, 20'h11200);
        chk({porch_line_share, pll_adjust_limit}, {8'h5a, 25'h246800});
        // Manual mode, clamp and gating
        wr(12'h48b, 8'h05);
        wr(12'h488, 8'h1a);
        wr(12'h489, 8'hbc);
        wr(12'h48a, 8'h3a);
        vfe_fe_model_i.blank(1'b1);
        chk({analog_gain, digital_gain}, {6'h1a, 12'habc});
        chk({clamp_level, porch_update_enable}, 4'hb);
        wr(12'h48b, 8'h88);
        chk({clamp_level, porch_update_enable}, 4'h6);
        wr(12'h48b, 8'h60);
        chk(digital_gain, 12'h5a3);
        vfe_fe_model_i.overflow(3);
        chk(sync_height_target, 8'hc5);
        wr(12'h48b, 8'h00);
        vfe_fe_model_i.overflow(3);
        chk(sync_height_target, 8'hc5);
        vfe_fe_model_i.blank(1'b0);
        // Each code, a stray field restarts
        wr(12'h487, 8'h00);
        repeat (2) vfe_fe_model_i.field(2'h3, 1'b1);
        for (int c = 0; c < 4; c++) begin
            wr(12'h487, {c[1:0], c[1:0], 4'h0});
            repeat ((2 << c) - 1) vfe_fe_model_i.field(c[1:0], c[0]);
            vfe_fe_model_i.field(~c[1:0], ~c[0]);
            repeat ((2 << c) - 1) vfe_fe_model_i.field(c[1:0], c[0]);
            chk({detected_lines_625, detected_format}, {~c[0], 2'(c - 1)});
            vfe_fe_model_i.field(c[1:0], c[0]);
            chk({detected_lines_625, detected_format}, {c[0], c[1:0]});
        end
        foreach (heights[i]) begin
            vfe_fe_model_i.sample(heights[i]);
            chk(gain_locked, locks[i]);
        end
        stop_test();
    end
endmodule
